/* File: include/cscr_pkg.sv */
// Package with the register map, status word layout and event types of the CPU status and control registers.
package cscr_pkg;

	// Register byte offsets on the APB register bus.
	localparam logic [7:0] CSCR_OFF_PSW          = 8'h00;
	localparam logic [7:0] CSCR_OFF_IRQ_SP       = 8'h04;
	localparam logic [7:0] CSCR_OFF_USER_SP      = 8'h08;
	localparam logic [7:0] CSCR_OFF_IRQ_BASE     = 8'h0C;
	localparam logic [7:0] CSCR_OFF_EXC_BASE     = 8'h10;
	localparam logic [7:0] CSCR_OFF_SAVED_PC     = 8'h14;
	localparam logic [7:0] CSCR_OFF_SAVED_STATUS = 8'h18;
	localparam logic [7:0] CSCR_OFF_FAST_VEC     = 8'h1C;
	localparam logic [7:0] CSCR_OFF_FLOAT_ST     = 8'h20;
	localparam logic [7:0] CSCR_OFF_STATE        = 8'h24;
	localparam logic [7:0] CSCR_OFF_ACTSP        = 8'h28;

	// Reset values.
	localparam logic [31:0] CSCR_RST_WORD  = 32'h0000_0000;
	localparam logic [3:0]  CSCR_RST_LEVEL = 4'h0;

	// Writable bits of the status word; all other bits read as zero.
	localparam logic [31:0] CSCR_PSW_WMASK  = 32'h0F13_000F;
	// Writable bits of the floating-point status word.
	localparam logic [31:0] CSCR_FLOAT_WMASK = 32'h0000_07FF;
	// Floating-point overflow flag and its exception enable.
	localparam int          CSCR_FLOAT_OVF   = 2;
	localparam int          CSCR_FLOAT_OVFEN = 10;
	// Vector numbers are scaled to word addresses by this shift.
	localparam int          CSCR_VEC_SHIFT  = 2;
	// Exception vector number used for a floating-point overflow.
	localparam logic [7:0]  CSCR_VEC_FPU    = 8'h15;

	// Processor status word layout.
	typedef struct packed {
		logic [3:0]  rsvd_31;
		logic [3:0]  interrupt_mask_level;
		logic [2:0]  rsvd_23;
		logic        processor_privilege_bit;
		logic [1:0]  rsvd_19;
		logic        stack_select;
		logic        irq_enable;
		logic [11:0] rsvd_15;
		logic        flag_o;
		logic        flag_s;
		logic        flag_z;
		logic        flag_c;
	} cscr_psw_t;

	// Interrupt request from the interrupt controller.
	typedef struct packed {
		logic       valid;
		logic       fast;
		logic [3:0] level;
		logic [7:0] vector;
	} cscr_irq_t;

	// Kind of redirection handed to the core.
	typedef enum logic [1:0] {
		CSCR_BR_EXC,
		CSCR_BR_IRQ,
		CSCR_BR_FAST,
		CSCR_BR_RETFAST
	} cscr_br_kind_t;

	// Redirection handed to the core.
	typedef struct packed {
		logic          valid;
		cscr_br_kind_t kind;
		logic [31:0]   addr;
	} cscr_branch_t;

endpackage

/* File: src/cscr_irq_gate.sv */
// Interrupt acceptance gate comparing request level against enable and mask level.
`timescale 1ns/1ps
module cscr_irq_gate (
	input  wire logic       pending,
	input  wire logic [3:0] req_level,
	input  wire logic [3:0] mask_level,
	input  wire logic       irq_enable,
	input  wire logic       core_ready,
	output logic            accept
);

	// Strictly greater only: a request at the mask level itself stays pending.
	assign accept = pending & irq_enable & core_ready & (req_level > mask_level);

endmodule // cscr_irq_gate

/* File: src/cscr_top.sv */
// CPU status word, stack pointers, vector bases and fast interrupt backup registers with an APB slave.
//
// How it works
// - Stack select 0 uses interrupt stack, 1 user stack.
// - Interrupt table base holds interrupt vector start.
// - Exception table base holds exception vector start.
// - Fast interrupt copies PC and status to backups.
// - Fast interrupt branches to fast vector register.
// - Float status reports overflow, may raise exception.
// - Status keeps carry, zero, sign, overflow flags.
// - Four-bit mask level, zero lowest, fifteen highest.
// - Accept only levels strictly above mask level.
// - Enable bit 0 blocks, 1 allows interrupts.
// - Enable bit resets 0; software sets it.
// - Exception acceptance clears enable bit.
// - Request flag updates regardless of enable bit.
// - Exception clears stack select and privilege bit.
`timescale 1ns/1ps
module cscr_top (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// APB slave.
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// Interrupt controller side.
	input  wire cscr_pkg::cscr_irq_t   irq_in,
	output logic                       irq_pending,
	output logic                       irq_ack,
	// Execution core side.
	input  wire logic                  core_ready,
	input  wire logic [31:0]           core_pc,
	input  wire logic                  flag_we,
	input  wire logic [3:0]            flag_in,
	input  wire logic                  fpu_we,
	input  wire logic [31:0]           fpu_status,
	input  wire logic                  exc_req,
	input  wire logic [7:0]            exc_vector,
	input  wire logic                  ret_fast,
	input  wire logic                  sp_we,
	input  wire logic [31:0]           sp_wdata,
	output logic      [31:0]           active_sp,
	output logic                       user_mode,
	output cscr_pkg::cscr_psw_t        psw_out,
	output cscr_pkg::cscr_branch_t     branch
);

	cscr_pkg::cscr_psw_t processor_status_word;
	cscr_pkg::cscr_psw_t saved_status_fast;
	logic [31:0]         interrupt_stack_pointer;
	logic [31:0]         user_stack_pointer;
	logic [31:0]         interrupt_table_base;
	logic [31:0]         exception_table_base;
	logic [31:0]         saved_pc_fast;
	logic [31:0]         fast_irq_vector;
	logic [31:0]         float_status_word;
	logic                pend_fast;
	logic [3:0]          pend_level;
	logic [7:0]          pend_vector;
	logic [3:0]          last_level;
	logic                irq_accept;
	logic                fpu_exc;
	logic                exc_take;
	logic                fast_take;
	logic                norm_take;
	logic                ret_take;
	logic                wr_en;
	logic                rd_en;
	logic                addr_hit;
	logic [31:0]         next_prdata;
	logic [31:0]         wr_psw;

	// Bus access qualifiers; the slave never stalls, so every access completes in its first access cycle.
	assign wr_en  = psel & penable & pwrite;
	assign rd_en  = psel & ~penable & ~pwrite;
	assign pready = 1'b1;

	// Address decode for the error answer.
	always_comb begin
		if (paddr == cscr_pkg::CSCR_OFF_PSW || paddr == cscr_pkg::CSCR_OFF_IRQ_SP) begin
			addr_hit = 1'b1;
		end else if (paddr == cscr_pkg::CSCR_OFF_USER_SP || paddr == cscr_pkg::CSCR_OFF_IRQ_BASE) begin
			addr_hit = 1'b1;
		end else if (paddr == cscr_pkg::CSCR_OFF_EXC_BASE || paddr == cscr_pkg::CSCR_OFF_SAVED_PC) begin
			addr_hit = 1'b1;
		end else if (paddr == cscr_pkg::CSCR_OFF_SAVED_STATUS || paddr == cscr_pkg::CSCR_OFF_FAST_VEC) begin
			addr_hit = 1'b1;
		end else if (paddr == cscr_pkg::CSCR_OFF_FLOAT_ST || paddr == cscr_pkg::CSCR_OFF_STATE) begin
			addr_hit = 1'b1;
		end else if (paddr == cscr_pkg::CSCR_OFF_ACTSP) begin
			addr_hit = 1'b1;
		end else begin
			addr_hit = 1'b0;
		end
	end

	// Unmapped addresses answer with an error and have no effect.
	assign pslverr = psel & penable & ~addr_hit;

	// Read multiplexer; the result is captured in the setup cycle.
	always_comb begin
		if (paddr == cscr_pkg::CSCR_OFF_PSW) begin
			next_prdata = processor_status_word;
		end else if (paddr == cscr_pkg::CSCR_OFF_IRQ_SP) begin
			next_prdata = interrupt_stack_pointer;
		end else if (paddr == cscr_pkg::CSCR_OFF_USER_SP) begin
			next_prdata = user_stack_pointer;
		end else if (paddr == cscr_pkg::CSCR_OFF_IRQ_BASE) begin
			next_prdata = interrupt_table_base;
		end else if (paddr == cscr_pkg::CSCR_OFF_EXC_BASE) begin
			next_prdata = exception_table_base;
		end else if (paddr == cscr_pkg::CSCR_OFF_SAVED_PC) begin
			next_prdata = saved_pc_fast;
		end else if (paddr == cscr_pkg::CSCR_OFF_SAVED_STATUS) begin
			next_prdata = saved_status_fast;
		end else if (paddr == cscr_pkg::CSCR_OFF_FAST_VEC) begin
			next_prdata = fast_irq_vector;
		end else if (paddr == cscr_pkg::CSCR_OFF_FLOAT_ST) begin
			next_prdata = float_status_word;
		end else if (paddr == cscr_pkg::CSCR_OFF_STATE) begin
			next_prdata = {16'h0000, pend_vector, last_level, 1'b0, pend_fast, user_mode, irq_pending};
		end else if (paddr == cscr_pkg::CSCR_OFF_ACTSP) begin
			next_prdata = active_sp;
		end else begin
			next_prdata = cscr_pkg::CSCR_RST_WORD;
		end
	end

	// Read data register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= cscr_pkg::CSCR_RST_WORD;
		end else if (rd_en) begin
			prdata <= next_prdata;
		end
	end

	// Event arbitration: exceptions outrank interrupts, and a fast return in the same cycle as either is dropped.
	assign fpu_exc   = fpu_we & fpu_status[cscr_pkg::CSCR_FLOAT_OVF]
	                 & float_status_word[cscr_pkg::CSCR_FLOAT_OVFEN];
	assign exc_take  = exc_req | fpu_exc;
	assign fast_take = ~exc_take & irq_accept & pend_fast;
	assign norm_take = ~exc_take & irq_accept & ~pend_fast;
	assign ret_take  = ~exc_take & ~irq_accept & ret_fast;
	assign irq_ack   = fast_take | norm_take;

	cscr_irq_gate u_irq_gate (
		.pending    (irq_pending),
		.req_level  (pend_level),
		.mask_level (processor_status_word.interrupt_mask_level),
		.irq_enable (processor_status_word.irq_enable),
		.core_ready (core_ready),
		.accept     (irq_accept)
	);

	// Request flag; a new request in the cycle of acceptance keeps the flag set, and the enable bit is ignored.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_pending <= 1'b0;
			pend_fast   <= 1'b0;
			pend_level  <= cscr_pkg::CSCR_RST_LEVEL;
			pend_vector <= 8'h00;
		end else if (irq_in.valid) begin
			irq_pending <= 1'b1;
			pend_fast   <= irq_in.fast;
			pend_level  <= irq_in.level;
			pend_vector <= irq_in.vector;
		end else if (irq_ack) begin
			irq_pending <= 1'b0;
		end
	end

	// Level of the last accepted interrupt, for software to inspect.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_level <= cscr_pkg::CSCR_RST_LEVEL;
		end else if (irq_ack) begin
			last_level <= pend_level;
		end
	end

	// Software image of the status word after a bus write, reserved bits forced to zero.
	assign wr_psw = pwdata & cscr_pkg::CSCR_PSW_WMASK;

	// Status word: bus writes, then core flag updates, then event effects, each later one winning.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			processor_status_word <= cscr_pkg::CSCR_RST_WORD;
		end else begin
			if (wr_en && paddr == cscr_pkg::CSCR_OFF_PSW) begin
				processor_status_word <= wr_psw;
			end
			if (flag_we) begin
				processor_status_word.flag_c <= flag_in[0];
				processor_status_word.flag_z <= flag_in[1];
				processor_status_word.flag_s <= flag_in[2];
				processor_status_word.flag_o <= flag_in[3];
			end
			if (exc_take || irq_ack) begin
				processor_status_word.irq_enable              <= 1'b0;
				processor_status_word.stack_select            <= 1'b0;
				processor_status_word.processor_privilege_bit <= 1'b0;
			end else if (ret_take) begin
				processor_status_word <= saved_status_fast & cscr_pkg::CSCR_PSW_WMASK;
			end
		end
	end

	// Fast interrupt backups replace the stack push, saving several memory cycles.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			saved_pc_fast     <= cscr_pkg::CSCR_RST_WORD;
			saved_status_fast <= cscr_pkg::CSCR_RST_WORD;
		end else if (fast_take) begin
			saved_pc_fast     <= core_pc;
			saved_status_fast <= processor_status_word;
		end else if (wr_en && paddr == cscr_pkg::CSCR_OFF_SAVED_PC) begin
			saved_pc_fast <= pwdata;
		end else if (wr_en && paddr == cscr_pkg::CSCR_OFF_SAVED_STATUS) begin
			saved_status_fast <= wr_psw;
		end
	end

	// Vector base and fast vector registers, written by software only.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			interrupt_table_base <= cscr_pkg::CSCR_RST_WORD;
			exception_table_base <= cscr_pkg::CSCR_RST_WORD;
			fast_irq_vector      <= cscr_pkg::CSCR_RST_WORD;
		end else if (wr_en && paddr == cscr_pkg::CSCR_OFF_IRQ_BASE) begin
			interrupt_table_base <= pwdata;
		end else if (wr_en && paddr == cscr_pkg::CSCR_OFF_EXC_BASE) begin
			exception_table_base <= pwdata;
		end else if (wr_en && paddr == cscr_pkg::CSCR_OFF_FAST_VEC) begin
			fast_irq_vector <= pwdata;
		end
	end

	// Floating-point status: the unit's report wins over a simultaneous software write.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			float_status_word <= cscr_pkg::CSCR_RST_WORD;
		end else if (fpu_we) begin
			float_status_word <= (fpu_status & cscr_pkg::CSCR_FLOAT_WMASK)
			                   | (float_status_word & (32'h1 << cscr_pkg::CSCR_FLOAT_OVFEN));
		end else if (wr_en && paddr == cscr_pkg::CSCR_OFF_FLOAT_ST) begin
			float_status_word <= pwdata & cscr_pkg::CSCR_FLOAT_WMASK;
		end
	end

	// Stack pointers; the core writes whichever one is active, and its write wins over the bus.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			interrupt_stack_pointer <= cscr_pkg::CSCR_RST_WORD;
			user_stack_pointer      <= cscr_pkg::CSCR_RST_WORD;
		end else if (sp_we) begin
			if (processor_status_word.stack_select) begin
				user_stack_pointer <= sp_wdata;
			end else begin
				interrupt_stack_pointer <= sp_wdata;
			end
		end else if (wr_en && paddr == cscr_pkg::CSCR_OFF_IRQ_SP) begin
			interrupt_stack_pointer <= pwdata;
		end else if (wr_en && paddr == cscr_pkg::CSCR_OFF_USER_SP) begin
			user_stack_pointer <= pwdata;
		end else if (wr_en && paddr == cscr_pkg::CSCR_OFF_ACTSP) begin
			if (processor_status_word.stack_select) begin
				user_stack_pointer <= pwdata;
			end else begin
				interrupt_stack_pointer <= pwdata;
			end
		end
	end

	// Active stack pointer and mode follow the status word without delay.
	assign active_sp = processor_status_word.stack_select ? user_stack_pointer : interrupt_stack_pointer;
	assign user_mode = processor_status_word.processor_privilege_bit;
	assign psw_out   = processor_status_word;

	// Redirection to the core, one cycle after the event is taken.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			branch <= '0;
		end else begin
			branch.valid <= exc_take | irq_ack | ret_take;
			if (exc_take) begin
				branch.kind <= cscr_pkg::CSCR_BR_EXC;
				branch.addr <= exception_table_base
				             + {22'h0, (exc_req ? exc_vector : cscr_pkg::CSCR_VEC_FPU), 2'b00};
			end else if (fast_take) begin
				branch.kind <= cscr_pkg::CSCR_BR_FAST;
				branch.addr <= fast_irq_vector;
			end else if (norm_take) begin
				branch.kind <= cscr_pkg::CSCR_BR_IRQ;
				branch.addr <= interrupt_table_base + {22'h0, pend_vector, 2'b00};
			end else if (ret_take) begin
				branch.kind <= cscr_pkg::CSCR_BR_RETFAST;
				branch.addr <= saved_pc_fast;
			end
		end
	end

endmodule // cscr_top

/* File: verification/cscr_irqc_model.sv */
// Interrupt controller model that issues one-cycle requests towards the status registers.
`timescale 1ns/1ps
module cscr_irqc_model (
	input  wire logic           pclk,
	input  wire logic           presetn,
	input  wire logic           go,
	input  wire logic           fast,
	input  wire logic [3:0]     level,
	input  wire logic [7:0]     vector,
	output cscr_pkg::cscr_irq_t irq_in
);
	// A request lasts one cycle; between requests the fields flip so a stale latch cannot pass unseen.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_in <= '0;
		end else if (go) begin
			irq_in <= {1'b1, fast, level, vector};
		end else begin
			irq_in <= {1'b0, ~irq_in.fast, ~irq_in.level, ~irq_in.vector};
		end
	end
endmodule // cscr_irqc_model

/* File: verification/cscr_top_checker.sv */
// Concurrent checks on the ports of the CPU status and control registers.
`timescale 1ns/1ps
module cscr_top_checker (
	input wire logic                   pclk,
	input wire logic                   presetn,
	input wire cscr_pkg::cscr_irq_t    irq_in,
	input wire logic                   irq_pending,
	input wire logic                   irq_ack,
	input wire logic                   core_ready,
	input wire logic                   flag_we,
	input wire logic [3:0]             flag_in,
	input wire logic                   exc_req,
	input wire logic                   ret_fast,
	input wire logic                   user_mode,
	input wire cscr_pkg::cscr_psw_t    psw_out,
	input wire cscr_pkg::cscr_branch_t branch
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Steps seen one cycle after an accepted event.
	sequence s_irq_br;
		branch.valid && (branch.kind == cscr_pkg::CSCR_BR_IRQ || branch.kind == cscr_pkg::CSCR_BR_FAST);
	endsequence
	sequence s_exc_br;
		branch.valid && branch.kind == cscr_pkg::CSCR_BR_EXC;
	endsequence
	sequence s_cleared;
		!psw_out.irq_enable && !psw_out.stack_select && !psw_out.processor_privilege_bit;
	endsequence
	property p_ack_gate;
		irq_ack |-> irq_pending && psw_out.irq_enable && core_ready && !exc_req;
	endproperty
	a_ack_gate: assert property (p_ack_gate) else $error("interrupt taken while blocked");
	property p_ack_clear;
		irq_ack |=> s_cleared;
	endproperty
	a_ack_clear: assert property (p_ack_clear) else $error("status not cleared on interrupt");
	property p_ack_br;
		irq_ack |=> s_irq_br;
	endproperty
	a_ack_br: assert property (p_ack_br) else $error("no interrupt redirection");
	property p_exc;
		exc_req |=> s_exc_br ##0 s_cleared;
	endproperty
	a_exc: assert property (p_exc) else $error("exception not taken with cleared status");
	property p_req_flag;
		irq_in.valid |=> irq_pending;
	endproperty
	a_req_flag: assert property (p_req_flag) else $error("request flag not set");
	property p_flags;
		flag_we && !ret_fast |=> psw_out[3:0] == $past(flag_in);
	endproperty
	a_flags: assert property (p_flags) else $error("condition flags not updated");
	property p_ret;
		ret_fast && !exc_req && !irq_ack |=> branch.valid && branch.kind == cscr_pkg::CSCR_BR_RETFAST;
	endproperty
	a_ret: assert property (p_ret) else $error("fast return not redirected");
	property p_mode;
		user_mode == psw_out.processor_privilege_bit && !($past(exc_req) && user_mode);
	endproperty
	a_mode: assert property (p_mode) else $error("mode output differs from status");
	property p_rst_enable;
		$rose(presetn) |-> !psw_out.irq_enable;
	endproperty
	a_rst_enable: assert property (p_rst_enable) else $error("enable bit set after reset");
endmodule // cscr_top_checker

bind cscr_top cscr_top_checker u_chk (.pclk(pclk), .presetn(presetn), .irq_in(irq_in), .irq_pending(irq_pending),
	.irq_ack(irq_ack), .core_ready(core_ready), .flag_we(flag_we), .flag_in(flag_in), .exc_req(exc_req),
	.ret_fast(ret_fast), .user_mode(user_mode), .psw_out(psw_out), .branch(branch));

/* File: verification/cscr_top_bench.sv */
// Self-checking bench for the CPU status and control registers.
`timescale 1ns/1ps
module cscr_top_bench;
	logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic                   core_ready, flag_we, fpu_we, exc_req, ret_fast, sp_we, go, fast;
	logic                   irq_pending, irq_ack, user_mode;
	logic [7:0]             paddr, exc_vector, vec;
	logic [3:0]             flag_in, lvl;
	logic [31:0]            pwdata, prdata, core_pc, fpu_status, sp_wdata, active_sp, q;
	cscr_pkg::cscr_irq_t    irq_in;
	cscr_pkg::cscr_psw_t    psw_out;
	cscr_pkg::cscr_branch_t branch;
	int                     failures, num_checks, n_ack;
	logic [7:0]             offs [5];

	cscr_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq_in(irq_in), .irq_pending(irq_pending), .irq_ack(irq_ack), .core_ready(core_ready),
		.core_pc(core_pc), .flag_we(flag_we), .flag_in(flag_in), .fpu_we(fpu_we), .fpu_status(fpu_status),
		.exc_req(exc_req), .exc_vector(exc_vector), .ret_fast(ret_fast), .sp_we(sp_we), .sp_wdata(sp_wdata),
		.active_sp(active_sp), .user_mode(user_mode), .psw_out(psw_out), .branch(branch));
	cscr_irqc_model u_irqc (.pclk(pclk), .presetn(presetn), .go(go), .fast(fast), .level(lvl),
		.vector(vec), .irq_in(irq_in));

	// Free-running bus clock.
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// Accepted interrupts are counted so blocked requests can be proven silent.
	always @(posedge pclk) begin
		if (irq_ack === 1'b1) n_ack <= n_ack + 1;
	end

	task automatic finish_test;
		if (failures == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			failures++;
		end
	endtask

	// One APB transfer; the request is held until pready is seen at a rising edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 20) begin
			failures++;
			finish_test;
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(q, e);
	endtask

	// Core event strobe: bits are flag, float, exception and fast return.
	task automatic ev(input logic [3:0] s, input logic [31:0] d);
		@(posedge pclk);
		{flag_we, fpu_we, exc_req, ret_fast} <= s;
		flag_in <= d[3:0];
		fpu_status <= d;
		exc_vector <= d[7:0];
		@(posedge pclk);
		{flag_we, fpu_we, exc_req, ret_fast} <= 4'h0;
	endtask

	task automatic raise(input logic f, input logic [3:0] l, input logic [7:0] v);
		@(posedge pclk);
		go <= 1'b1;
		fast <= f;
		lvl <= l;
		vec <= v;
		@(posedge pclk);
		go <= 1'b0;
	endtask

	// The redirection lasts one cycle, so it is looked for just after each edge.
	task automatic wait_br(input logic [1:0] k, input logic [31:0] a);
		int i;
		for (i = 0; i < 20; i++) begin
			#1;
			if (branch.valid === 1'b1) break;
			@(posedge pclk);
		end
		if (i == 20) begin
			failures++;
			finish_test;
		end
		chk({30'h0, branch.kind}, {30'h0, k});
		chk(branch.addr, a);
	endtask

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, flag_we, flag_in, fpu_we, fpu_status} = '0;
		{exc_req, exc_vector, ret_fast, sp_we, sp_wdata, go, fast, lvl, vec, core_ready} = '0;
		core_pc = 32'h0000_0000;
		{failures, num_checks, n_ack} = '0;
		offs = '{cscr_pkg::CSCR_OFF_IRQ_SP, cscr_pkg::CSCR_OFF_USER_SP, cscr_pkg::CSCR_OFF_IRQ_BASE,
			cscr_pkg::CSCR_OFF_EXC_BASE, cscr_pkg::CSCR_OFF_FAST_VEC};
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		core_ready <= 1'b1;
		rd(cscr_pkg::CSCR_OFF_PSW, 32'h0000_0000);
		ev(4'h8, 32'h0000_000A);
		#1 chk(psw_out[3:0], 4'hA);
		for (int k = 0; k < 5; k++) apb(1'b1, offs[k], 32'h1000 * (k + 1));
		for (int k = 0; k < 5; k++) rd(offs[k], 32'h1000 * (k + 1));
		apb(1'b1, cscr_pkg::CSCR_OFF_PSW, 32'hFFFF_FFFF);
		rd(cscr_pkg::CSCR_OFF_PSW, 32'h0F13_000F);
		apb(1'b1, cscr_pkg::CSCR_OFF_PSW, 32'h0000_0000);
		rd(8'h40, 32'h0000_0000);
		chk(err, 1'b1);
		raise(1'b0, 4'h5, 8'h10);
		repeat (6) @(posedge pclk);
		#1 chk(n_ack, 0);
		chk(irq_pending, 1'b1);
		apb(1'b1, cscr_pkg::CSCR_OFF_PSW, 32'h0501_0000);
		repeat (4) @(posedge pclk);
		#1 chk(n_ack, 0);
		apb(1'b1, cscr_pkg::CSCR_OFF_PSW, 32'h0401_0000);
		wait_br(cscr_pkg::CSCR_BR_IRQ, 32'h0000_3040);
		chk(psw_out, 32'h0400_0000);
		core_pc <= 32'h1234_5678;
		apb(1'b1, cscr_pkg::CSCR_OFF_PSW, 32'h0013_0005);
		#1 chk(active_sp, 32'h0000_2000);
		chk(user_mode, 1'b1);
		raise(1'b1, 4'h1, 8'h00);
		wait_br(cscr_pkg::CSCR_BR_FAST, 32'h0000_5000);
		chk(psw_out, 32'h0000_0005);
		chk(active_sp, 32'h0000_1000);
		rd(cscr_pkg::CSCR_OFF_ACTSP, 32'h0000_1000);
		apb(1'b1, cscr_pkg::CSCR_OFF_ACTSP, 32'h0000_1100);
		rd(cscr_pkg::CSCR_OFF_IRQ_SP, 32'h0000_1100);
		rd(cscr_pkg::CSCR_OFF_SAVED_PC, 32'h1234_5678);
		rd(cscr_pkg::CSCR_OFF_SAVED_STATUS, 32'h0013_0005);
		rd(cscr_pkg::CSCR_OFF_STATE, 32'h0000_0014);
		ev(4'h1, 32'h0000_0000);
		wait_br(cscr_pkg::CSCR_BR_RETFAST, 32'h1234_5678);
		chk(psw_out, 32'h0013_0005);
		ev(4'h2, 32'h0000_0003);
		wait_br(cscr_pkg::CSCR_BR_EXC, 32'h0000_400C);
		chk(psw_out, 32'h0000_0005);
		apb(1'b1, cscr_pkg::CSCR_OFF_FLOAT_ST, 32'h0000_0400);
		ev(4'h4, 32'h0000_0004);
		wait_br(cscr_pkg::CSCR_BR_EXC, 32'h0000_4054);
		rd(cscr_pkg::CSCR_OFF_FLOAT_ST, 32'h0000_0404);
		finish_test;
	end
endmodule // cscr_top_bench
